// ---- src/sewc_mem.sv ----
// Bit-masked write memory with registered read port
`timescale 1ns/1ns
`default_nettype none
module sewc_mem #(
   parameter int AW = 15,
   parameter int DW = 68
) (
   // Clock
   input wire logic clk_sys_in,
   // Write port
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic [DW-1:0] wmask_in,
   // Read port
   input wire logic [AW-1:0] raddr_in,
   output logic [DW-1:0] rdata_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem[waddr_in] <= (mem[waddr_in] & ~wmask_in) | (wdata_in & wmask_in);
      end
      rdata_out <= mem[raddr_in];
   end
endmodule
`default_nettype wire

// ---- src/sewc_pkg.sv ----
// Constants and types shared by the write command engine
package sewc_pkg;
   // Bus widths
   localparam int DQ_W = 68;
   localparam int CMD_W = 10;
   localparam int LOC_W = 15;
   localparam int DEPTH = 32768;
   localparam int SRAM_ADDR_OUT_W = 22;
   localparam int CNT_W = 8;
   localparam int CYC_W = 9;
   // Command field positions
   localparam int CMD_BURST_BIT = 2;
   localparam int CMD_GMI_LSB = 3;
   localparam int CMD_SRAM_ADDR_OUT_LSB = 7;
   localparam int CMD_NORMAL_BIT = 9;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // Address word field positions
   localparam int DQ_IND_BIT = 29;
   localparam int DQ_SSR_LSB = 26;
   localparam int DQ_ID_LSB = 21;
   localparam int DQ_TGT_LSB = 19;
   localparam logic [4:0] ID_BROADCAST = 5'h1f;
   localparam logic [1:0] TGT_DATA = 2'h0;
   localparam logic [1:0] TGT_MASK = 2'h1;
   localparam logic [1:0] TGT_SRAM = 2'h2;
   localparam logic [1:0] TGT_REG = 2'h3;
   // Internal register addresses on the command bus
   localparam logic [5:0] RA_GMR0 = 6'h00;
   localparam logic [5:0] RA_SSR0 = 6'h08;
   localparam logic [5:0] RA_BURST = 6'h10;
   // Burst control layout
   localparam int BC_CNT_LSB = 16;
   // Avalon byte offsets
   localparam logic [9:0] OFS_UNIT = 10'h000;
   localparam logic [9:0] OFS_BURST = 10'h004;
   localparam logic [9:0] OFS_STATUS = 10'h008;
   localparam logic [9:0] OFS_PROBE = 10'h00c;
   localparam logic [9:0] OFS_PDATA0 = 10'h010;
   localparam logic [9:0] OFS_SSR0 = 10'h020;
   localparam logic [9:0] OFS_GMR0 = 10'h040;
   // Reset values
   localparam logic [4:0] RST_UNIT = 5'h00;
   localparam logic [CNT_W-1:0] RST_COUNT = 8'h01;
   // Cycle numbers within an operation
   localparam logic [CYC_W-1:0] CYC_FIRST_DATA = 9'h002;
   localparam logic [CYC_W-1:0] CYC_FIRST_EOT = 9'h003;
   typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_GAP, ST_BURST, ST_TAIL} sewc_state_t;
endpackage

// ---- src/sewc_top.sv ----
// Write command engine of the search table device
// Summary of operation
// [RULE_01] Command burst flag 1 requests burst, 0 single; bursts hit data or mask arrays.
// [RULE_02] Single write takes three cycles; each further burst access adds one cycle.
// [RULE_03] Host holds command valid, write opcode and address through cycles 1A and 1B.
// [RULE_04] Host drives command bits 5..3 with the global mask index.
// [RULE_05] Upper SRAM address bits come on upper command lines and reach SRAM outputs.
// [RULE_06] Host drives command bit 9 low for an ordinary write.
// [RULE_07] Accept only on unit number match of address bits 25..21, or all ones.
// [RULE_08] Cycle 2 carries 68-bit write data; cycle 3 idle before next operation.
// [RULE_09] Host programs burst control with start and count; burst lasts count plus two.
// [RULE_10] Array writes change only bits set in the selected global mask.
// [RULE_11] Burst ignores address bits 14..0, uses and increments the burst pointer.
// [RULE_12] Burst cycles 3 to n+1 carry data for successive incremented locations; the code takes burst data in cycles 2 to n+1.
// [RULE_13] Burst drives end of transfer low cycles 3..n, high in cycle n+1; for a count of one or zero the code never drives it high.
// [RULE_14] Cycle n+2 drives end of transfer low, then releases it.
// [RULE_15] Register target 11 in bits 20..19, register address in bits 5..0.
// [RULE_16] Single write targets 00 data, 01 mask, 10 SRAM; bits 14..0 location.
// [RULE_17] Bit 29 set forms location from hit result register, low bits ORed.
// [RULE_18] Write opcode is 01 on command bits 1..0.
// [RULE_19] Host aligns each A and B cycle pair with the phase marker.
// [RULE_20] Unselected device changes nothing and leaves end of transfer released.
`timescale 1ns/1ns
`default_nettype none
module sewc_top
   import sewc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Command and data pins
   input wire logic command_valid_in,
   input wire logic [CMD_W-1:0] cmd_in,
   input wire logic phase_marker_n_in,
   input wire logic [DQ_W-1:0] dq_in,
   // End of transfer pin
   output logic transfer_last_out,
   output logic transfer_last_oe_n_out,
   // External SRAM
   output logic [SRAM_ADDR_OUT_W-1:0] sram_addr_out,
   output logic [DQ_W-1:0] sram_data_out,
   output logic sram_we_n_out,
   // Avalon-MM slave
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // Pin synchronisers
   logic cv_s1, cv_s2, phs_s1, phs_s2;
   logic [CMD_W-1:0] cmd_s1, cmd_s2;
   logic [DQ_W-1:0] dq_s1, dq_s2;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cv_s1 <= 1'b0;
         cv_s2 <= 1'b0;
         phs_s1 <= 1'b1;
         phs_s2 <= 1'b1;
         cmd_s1 <= '0;
         cmd_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
      end else begin
         cv_s1 <= command_valid_in;
         cv_s2 <= cv_s1;
         phs_s1 <= phase_marker_n_in;
         phs_s2 <= phs_s1;
         cmd_s1 <= cmd_in;
         cmd_s2 <= cmd_s1;
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
      end
   end

   // State and registers
   sewc_state_t state;
   logic [CYC_W-1:0] cyc;
   logic [1:0] tgt_q;
   logic [LOC_W-1:0] loc_q;
   logic [2:0] gmi_q;
   logic [1:0] sram_addr_out_hi_q;
   logic [5:0] reg_addr_q;
   logic [DQ_W-1:0] global_mask_set [0:7];
   logic [LOC_W-1:0] hit_result_reg [0:7];
   logic [LOC_W-1:0] wr_burst_pointer;
   logic [CNT_W-1:0] burst_count;
   logic [4:0] unit_number;
   logic [LOC_W:0] probe;
   logic [DQ_W-1:0] data_rd, mask_rd;

   // One step per instruction cycle, at its A half
   wire step = ~phs_s2; // RULE_19
   wire is_write = cv_s2 && (cmd_s2[1:0] == OP_WRITE) && !cmd_s2[CMD_NORMAL_BIT]; // RULE_18 RULE_06
   wire [4:0] dq_id = dq_s2[DQ_ID_LSB +: 5];
   wire id_hit = (dq_id == unit_number) || (dq_id == ID_BROADCAST); // RULE_07
   wire start = step && (state == ST_IDLE) && is_write && id_hit; // RULE_20
   wire is_burst = cmd_s2[CMD_BURST_BIT]; // RULE_01
   wire [1:0] dq_tgt = dq_s2[DQ_TGT_LSB +: 2];
   wire [2:0] ssr_sel = dq_s2[DQ_SSR_LSB +: 3];
   wire [LOC_W-1:0] ssr_v = hit_result_reg[ssr_sel];
   wire [LOC_W-1:0] ind_loc = {ssr_v[14:2], ssr_v[1] | dq_s2[1], ssr_v[0] | dq_s2[0]}; // RULE_17
   wire [LOC_W-1:0] dir_loc = dq_s2[LOC_W-1:0]; // RULE_16
   wire [LOC_W-1:0] new_loc = dq_s2[DQ_IND_BIT] ? ind_loc : dir_loc;
   // Burst length; a count of zero behaves as one
   wire [CNT_W-1:0] n_eff = (burst_count == '0) ? 8'h01 : burst_count;
   wire [CYC_W-1:0] last_cyc = {1'b0, n_eff} + 9'h001;
   wire [CYC_W-1:0] cyc_nx = cyc + 9'h001;
   wire data_step = step && ((state == ST_DATA) || (state == ST_BURST)); // RULE_08
   wire in_burst = (state == ST_BURST);
   wire [LOC_W-1:0] wr_loc = in_burst ? wr_burst_pointer : loc_q; // RULE_11
   wire arr_tgt = (tgt_q == TGT_DATA) || (tgt_q == TGT_MASK);
   wire data_we = data_step && (tgt_q == TGT_DATA); // RULE_16
   wire mask_we = data_step && (tgt_q == TGT_MASK);
   wire sram_we = data_step && !in_burst && (tgt_q == TGT_SRAM);
   wire reg_we = data_step && !in_burst && (tgt_q == TGT_REG); // RULE_15
   wire [DQ_W-1:0] sel_mask = global_mask_set[gmi_q]; // RULE_10

   // Command sequencer
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_IDLE;
         cyc <= '0;
         tgt_q <= '0;
         loc_q <= '0;
         gmi_q <= '0;
         sram_addr_out_hi_q <= '0;
         reg_addr_q <= '0;
         transfer_last_out <= 1'b0;
         transfer_last_oe_n_out <= 1'b1;
      end else if (step) begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  tgt_q <= dq_tgt;
                  loc_q <= new_loc;
                  gmi_q <= cmd_s2[CMD_GMI_LSB +: 3]; // RULE_04
                  sram_addr_out_hi_q <= cmd_s2[CMD_SRAM_ADDR_OUT_LSB +: 2]; // RULE_05
                  reg_addr_q <= dq_s2[5:0]; // RULE_15
                  cyc <= CYC_FIRST_DATA;
                  if (is_burst && (dq_tgt[1] == 1'b0)) begin
                     state <= ST_BURST; // RULE_01
                  end else begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               state <= ST_GAP; // RULE_02
            end
            ST_GAP: begin
               state <= ST_IDLE; // RULE_08
            end
            ST_BURST: begin
               cyc <= cyc_nx;
               if (cyc >= last_cyc) begin
                  state <= ST_TAIL;
                  transfer_last_out <= 1'b0; // RULE_14
                  transfer_last_oe_n_out <= 1'b0;
               end else if (cyc_nx >= CYC_FIRST_EOT) begin
                  transfer_last_oe_n_out <= 1'b0; // RULE_13
                  transfer_last_out <= (cyc_nx == last_cyc);
               end
            end
            ST_TAIL: begin
               state <= ST_IDLE;
               transfer_last_out <= 1'b0;
               transfer_last_oe_n_out <= 1'b1; // RULE_14
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // External SRAM write
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sram_addr_out <= '0;
         sram_data_out <= '0;
         sram_we_n_out <= 1'b1;
      end else begin
         sram_we_n_out <= ~sram_we;
         if (sram_we) begin
            sram_addr_out <= {sram_addr_out_hi_q, 5'h00, loc_q}; // RULE_05
            sram_data_out <= dq_s2;
         end
      end
   end

   // Data and mask arrays
   sewc_mem #(.AW(LOC_W), .DW(DQ_W)) u_data (
      .clk_sys_in(clk_sys_in),
      .we_in(data_we),
      .waddr_in(wr_loc),
      .wdata_in(dq_s2),
      .wmask_in(sel_mask),
      .raddr_in(probe[LOC_W-1:0]),
      .rdata_out(data_rd)
   );
   sewc_mem #(.AW(LOC_W), .DW(DQ_W)) u_mask (
      .clk_sys_in(clk_sys_in),
      .we_in(mask_we),
      .waddr_in(wr_loc),
      .wdata_in(dq_s2),
      .wmask_in(sel_mask),
      .raddr_in(probe[LOC_W-1:0]),
      .rdata_out(mask_rd)
   );

   // Avalon decode
   wire bus_wr = avs_write && !avs_waitrequest;
   wire [2:0] a_ssr = avs_address[4:2];
   // Mask sets sit at 16-byte strides from their base, not at a power-of-two boundary
   wire [9:0] gmr_ofs = avs_address - OFS_GMR0;
   wire [2:0] a_gmr = gmr_ofs[6:4];
   wire [1:0] a_word = avs_address[3:2];
   wire hit_ssr = (avs_address[9:5] == OFS_SSR0[9:5]);
   wire hit_gmr = (gmr_ofs[9:7] == 3'h0) && (a_word != 2'h3);
   wire hit_pd = (avs_address[9:4] == OFS_PDATA0[9:4]) && (a_word != 2'h3);
   wire [DQ_W-1:0] probe_rd = probe[LOC_W] ? mask_rd : data_rd;
   wire [95:0] probe_w = {28'h0, probe_rd};
   wire [95:0] gmr_w = {28'h0, global_mask_set[a_gmr]};
   wire [31:0] burst_w = {8'h0, burst_count, 1'b0, wr_burst_pointer};
   wire busy = (state != ST_IDLE);
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0;
      if (avs_address == OFS_UNIT) begin
         rd_mux = {27'h0, unit_number};
      end else if (avs_address == OFS_BURST) begin
         rd_mux = burst_w;
      end else if (avs_address == OFS_STATUS) begin
         rd_mux = {29'h0, ~transfer_last_oe_n_out, transfer_last_out, busy};
      end else if (avs_address == OFS_PROBE) begin
         rd_mux = {16'h0, probe};
      end else if (hit_pd) begin
         rd_mux = probe_w[a_word*32 +: 32];
      end else if (hit_ssr) begin
         rd_mux = {17'h0, hit_result_reg[a_ssr]};
      end else if (hit_gmr) begin
         rd_mux = gmr_w[a_word*32 +: 32];
      end
   end

   // Avalon handshake: one wait cycle per access
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Register file; command bus writes win over software
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 8; i++) begin
            global_mask_set[i] <= '0;
            hit_result_reg[i] <= '0;
         end
         wr_burst_pointer <= '0;
         burst_count <= RST_COUNT;
         unit_number <= RST_UNIT;
         probe <= '0;
      end else if (reg_we) begin
         if (reg_addr_q[5:3] == RA_GMR0[5:3]) begin
            global_mask_set[reg_addr_q[2:0]] <= dq_s2;
         end else if (reg_addr_q[5:3] == RA_SSR0[5:3]) begin
            hit_result_reg[reg_addr_q[2:0]] <= dq_s2[LOC_W-1:0];
         end else if (reg_addr_q == RA_BURST) begin
            wr_burst_pointer <= dq_s2[LOC_W-1:0];
            burst_count <= dq_s2[BC_CNT_LSB +: CNT_W];
         end
      end else if (data_step && in_burst && arr_tgt) begin
         wr_burst_pointer <= wr_burst_pointer + 15'h0001; // RULE_11 RULE_12
      end else if (bus_wr) begin
         if (avs_address == OFS_UNIT) begin
            unit_number <= avs_writedata[4:0];
         end else if (avs_address == OFS_BURST) begin
            wr_burst_pointer <= avs_writedata[LOC_W-1:0];
            burst_count <= avs_writedata[BC_CNT_LSB +: CNT_W];
         end else if (avs_address == OFS_PROBE) begin
            probe <= avs_writedata[LOC_W:0];
         end else if (hit_ssr) begin
            hit_result_reg[a_ssr] <= avs_writedata[LOC_W-1:0];
         end else if (hit_gmr) begin
            if (a_word == 2'h2) begin
               global_mask_set[a_gmr][67:64] <= avs_writedata[3:0];
            end else if (a_word == 2'h1) begin
               global_mask_set[a_gmr][63:32] <= avs_writedata;
            end else begin
               global_mask_set[a_gmr][31:0] <= avs_writedata;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/sewc_host.sv ----
// Host controller model driving the command and data pins
`timescale 1ns/1ns
`default_nettype none
module sewc_host
   import sewc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Command and data pins
   output logic command_valid_out,
   output logic [CMD_W-1:0] cmd_out,
   output logic phase_marker_n_out,
   output logic [DQ_W-1:0] dq_out
);
   initial begin
      command_valid_out = 1'b0;
      cmd_out = '0;
      dq_out = '0;
      phase_marker_n_out = 1'b1;
   end
   // Cycle A marked low, alternating every clock
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) phase_marker_n_out <= 1'b1;
      else phase_marker_n_out <= ~phase_marker_n_out;
   end
   function automatic logic [DQ_W-1:0] rnd();
      return DQ_W'({$urandom, $urandom, $urandom});
   endfunction
   // Drive at an A edge, hold through B
   task automatic cyc(input logic v, input logic [CMD_W-1:0] c, input logic [DQ_W-1:0] d);
      do @(posedge clk_sys_in); while (phase_marker_n_out !== 1'b1);
      command_valid_out <= v;
      cmd_out <= c;
      dq_out <= d;
      @(posedge clk_sys_in);
   endtask
   // Instruction, data words, idle cycle; released bus shows noise
   task automatic op(input logic [CMD_W-1:0] c, input logic [DQ_W-1:0] a,
                     input logic [DQ_W-1:0] w [$]);
      cyc(1'b1, c, a);
      foreach (w[i]) cyc(1'b0, '0, w[i]);
      cyc(1'b0, '0, rnd());
   endtask
endmodule
`default_nettype wire

// ---- tb/sewc_top_properties.sv ----
// Port assertions of the write command engine
`timescale 1ns/1ns
`default_nettype none
module sewc_top_properties
   import sewc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Watched ports
   input wire logic transfer_last_out,
   input wire logic transfer_last_oe_n_out,
   input wire logic [SRAM_ADDR_OUT_W-1:0] sram_addr_out,
   input wire logic sram_we_n_out,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   sram_gap_a: assert property ($fell(sram_we_n_out) |=> sram_we_n_out [*5])
      else $error("sram strobe too long or too close");
   sram_hole_a: assert property (!sram_we_n_out |-> sram_addr_out[19:15] == 5'h00)
      else $error("sram address gap bits set");
   eot_seq_a: assert property ($rose(transfer_last_out) |->
      (!transfer_last_oe_n_out && transfer_last_out) [*2] ##1
      (!transfer_last_oe_n_out && !transfer_last_out) [*2] ##1 transfer_last_oe_n_out)
      else $error("end of transfer tail wrong");
   eot_start_a: assert property ($fell(transfer_last_oe_n_out) |-> !transfer_last_out)
      else $error("end of transfer starts high");
   eot_release_a: assert property ($rose(transfer_last_oe_n_out) |-> !$past(transfer_last_out))
      else $error("end of transfer released while high");
   wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low too long");
   wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   rdata_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata))
      else $error("read data changed without read");
endmodule
bind sewc_top sewc_top_properties u_props (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
   .transfer_last_out(transfer_last_out), .transfer_last_oe_n_out(transfer_last_oe_n_out),
   .sram_addr_out(sram_addr_out), .sram_we_n_out(sram_we_n_out),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

// ---- tb/test_search_engine_write_command.sv ----
// Self-checking bench for the write command engine
`timescale 1ns/1ns
`default_nettype none
module test_search_engine_write_command import sewc_pkg::*;;
   logic clk_sys_in, command_valid, phase_marker_n, tl, tl_oe_n, sram_we_n, avs_waitrequest;
   logic resetn_in = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [9:0] avs_address = 10'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [CMD_W-1:0] cmd;
   logic [DQ_W-1:0] dq, sram_data;
   logic [SRAM_ADDR_OUT_W-1:0] sram_addr;
   logic [4:0] u;
   int num_errors = 0, comparisons = 0, n_drv = 0, n_hi = 0;
   logic [67:0] gm [8];
   logic [67:0] mdl [logic [15:0]];
   logic [89:0] sq [$];
   logic [89:0] e;
   sewc_top DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .command_valid_in(command_valid),
      .cmd_in(cmd), .phase_marker_n_in(phase_marker_n), .dq_in(dq), .transfer_last_out(tl),
      .transfer_last_oe_n_out(tl_oe_n), .sram_addr_out(sram_addr), .sram_data_out(sram_data),
      .sram_we_n_out(sram_we_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   sewc_host host (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .command_valid_out(command_valid), .cmd_out(cmd), .phase_marker_n_out(phase_marker_n),
      .dq_out(dq));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [67:0] x, input logic [67:0] g);
      comparisons++;
      if (g !== x) begin
         num_errors++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic av(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys_in); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic [CMD_W-1:0] cm(logic b, logic [2:0] gi, logic [1:0] sa);
      return {1'b0, sa, 1'b0, gi, b, OP_WRITE};
   endfunction
   function automatic logic [DQ_W-1:0] ad(logic [2:0] ss, logic [4:0] id, logic [1:0] t,
                                          logic [14:0] l, logic ind);
      return {38'h0, ind, ss, id, t, 4'h0, l};
   endfunction
   task automatic mw(input logic m, input logic [14:0] l, input logic [2:0] i, input logic [67:0] d);
      logic [67:0] o;
      o = mdl.exists({m, l}) ? mdl[{m, l}] : 68'h0;
      mdl[{m, l}] = (o & ~gm[i]) | (d & gm[i]);
   endtask
   task automatic probe(input logic m, input logic [14:0] l);
      logic [31:0] w0, w1, w2;
      av(OFS_PROBE, 1'b1, {16'h0000, m, l}, w0);
      repeat (2) @(posedge clk_sys_in);
      av(OFS_PDATA0, 1'b0, 32'h0, w0);
      av(OFS_PDATA0 + 10'h004, 1'b0, 32'h0, w1);
      av(OFS_PDATA0 + 10'h008, 1'b0, 32'h0, w2);
      chk("array word", mdl[{m, l}], {w2[3:0], w1, w0});
   endtask
   task automatic rw(input logic [5:0] ra, input logic [67:0] d);
      logic [67:0] q [$];
      q = {d};
      host.op(cm(1'b0, 3'h0, 2'h0), ad(3'h0, u, TGT_REG, 15'(ra), 1'b0), q);
   endtask
   always @(posedge clk_sys_in) begin
      if (tl_oe_n === 1'b0) n_drv++;
      if (tl_oe_n === 1'b0 && tl === 1'b1) n_hi++;
      if (sram_we_n === 1'b0) begin
         e = sq.pop_front();
         chk("sram addr", 68'(e[89:68]), 68'(sram_addr));
         chk("sram data", e[67:0], sram_data);
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      finish_test();
   end
   initial begin
      logic [31:0] r;
      logic [14:0] l, p, h;
      logic [67:0] d;
      logic [67:0] q [$];
      logic [CMD_W-1:0] c;
      void'($urandom(91));
      repeat (20) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      av(OFS_UNIT, 1'b0, 32'h0, r);
      chk("unit", 68'(RST_UNIT), 68'(r));
      u = 5'(2 + $urandom % 28);
      av(OFS_UNIT, 1'b1, 32'(u), r);
      av(OFS_UNIT, 1'b0, 32'h0, r);
      chk("unit", 68'(u), 68'(r));
      av(10'h3fc, 1'b0, 32'h0, r);
      chk("unmapped", 68'h0, 68'(r));
      gm[0] = '1;
      gm[1] = host.rnd();
      for (int i = 0; i < 6; i++) av(OFS_GMR0 + 10'(i / 3 * 16 + i % 3 * 4), 1'b1,
                                     32'(gm[i / 3] >> (i % 3 * 32)), r);
      for (int k = 0; k < 4; k++) begin
         l = 15'($urandom);
         for (int i = 0; i < 2; i++) begin
            d = host.rnd();
            q = {d};
            host.op(cm(1'b0, 3'(i), 2'h0), ad(3'h0, k > 1 ? ID_BROADCAST : u, 2'(k % 2), l, 1'b0), q);
            mw(k[0], l, 3'(i), d);
         end
         probe(k[0], l);
      end
      for (int k = 0; k < 3; k++) begin
         c = cm(1'b0, 3'h0, 2'h0) | (k == 1 ? 10'h200 : 10'h000) | (k == 2 ? 10'h002 : 10'h000);
         q = {host.rnd()};
         host.op(c, ad(3'h0, k == 0 ? u ^ 5'h01 : u, TGT_MASK, l, 1'b0), q);
         probe(1'b1, l);
      end
      h = 15'($urandom);
      rw(RA_SSR0 + 6'h02, 68'(h));
      av(OFS_SSR0 + 10'h008, 1'b0, 32'h0, r);
      chk("hit result", 68'(h), 68'(r[14:0]));
      l = 15'($urandom);
      d = host.rnd();
      q = {d};
      host.op(cm(1'b0, 3'h0, 2'h0), ad(3'h2, u, TGT_DATA, l, 1'b1), q);
      mw(1'b0, {h[14:2], h[1:0] | l[1:0]}, 3'h0, d);
      probe(1'b0, {h[14:2], h[1:0] | l[1:0]});
      c = cm(1'b0, 3'($urandom), 2'($urandom));
      d = host.rnd();
      q = {d};
      sq.push_back({c[8:7], 5'h00, l, d});
      host.op(c, ad(3'h0, u, TGT_SRAM, l, 1'b0), q);
      for (int n = 1; n < 5; n += 2) begin
         p = 15'($urandom);
         rw(RA_BURST, 68'({8'(n), 1'b0, p}));
         q = {};
         for (int k = 0; k < n; k++) begin
            q.push_back(host.rnd());
            mw(n[1], p + 15'(k), 3'h0, q[k]);
         end
         n_drv = 0;
         n_hi = 0;
         host.op(cm(1'b1, 3'h0, 2'h0), ad(3'h0, u, {1'b0, n[1]}, 15'($urandom), 1'b0), q);
         for (int k = 0; k < n; k++) probe(n[1], p + 15'(k));
         chk("eot driven", 68'(2 * n), 68'(n_drv));
         chk("eot high", n == 1 ? 68'h0 : 68'h2, 68'(n_hi));
      end
      chk("sram left", 68'h0, 68'(sq.size()));
      finish_test();
   end
endmodule
`default_nettype wire
